// ### nps_pkg.sv
// Shared constants, types and decoders for the serial program sequencer.
package nps_pkg;
  // Link framing.
  localparam int CMD_BITS = 8;
  localparam int PAY_BITS = 24;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [15:0] CFG_RESET = 16'hFFFF;
  localparam logic [15:0] LATCH_RESET = 16'hFFFF;
  localparam int PROT_WORD = 4;
  localparam int PROT_CP_BIT = 0;
  localparam int PROT_CPD_BIT = 1;
  // Command codes.
  localparam logic [7:0] OP_LOAD = 8'h00;
  localparam logic [7:0] OP_LOAD_INC = 8'h02;
  localparam logic [7:0] OP_LOAD_PC = 8'h80;
  localparam logic [7:0] OP_BULK = 8'h18;
  localparam logic [7:0] OP_ROW = 8'hF0;
  localparam logic [7:0] OP_INC = 8'hF8;
  localparam logic [7:0] OP_READ = 8'hFC;
  localparam logic [7:0] OP_READ_INC = 8'hFE;
  localparam logic [7:0] OP_SELF = 8'hE0;
  localparam logic [7:0] OP_EXT_BEGIN = 8'hC0;
  localparam logic [7:0] OP_EXT_END = 8'h82;
  // Region selectors on the top address bits.
  localparam logic [5:0] SEL_ID = 6'h20;
  localparam logic [5:0] SEL_CFG = 6'h30;
  // Times in nanoseconds and the clock rate.
  localparam int CLK_NS = 10;
  localparam int GAP_NS = 1_000;
  localparam int EXIT_NS = 1_000;
  localparam int BULK_NS = 25_200_000;
  localparam int ROW_NS = 2_800_000;
  localparam int WR_FAST_NS = 2_800_000;
  localparam int WR_SLOW_NS = 5_600_000;
  localparam int EXT_MIN_NS = 1_000_000;
  localparam int EXT_MAX_NS = 2_100_000;
  localparam int DIS_NS = 300_000;
  // Device limits are longest times, so they round down.
  localparam int DEV_BULK_CYC = BULK_NS / CLK_NS;
  localparam int DEV_ROW_CYC = ROW_NS / CLK_NS;
  localparam int DEV_WR_FAST_CYC = WR_FAST_NS / CLK_NS;
  localparam int DEV_WR_SLOW_CYC = WR_SLOW_NS / CLK_NS;
  // Host waits are least times, so they round up.
  localparam int SYNC_SLACK_CYC = 8;
  localparam int HOST_GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_EXIT_CYC = (EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_BULK_CYC = (BULK_NS + CLK_NS - 1) / CLK_NS + SYNC_SLACK_CYC;
  localparam int HOST_ROW_CYC = (ROW_NS + CLK_NS - 1) / CLK_NS + SYNC_SLACK_CYC;
  localparam int HOST_WR_CYC = (WR_SLOW_NS + CLK_NS - 1) / CLK_NS + SYNC_SLACK_CYC;
  localparam int HOST_EXT_CYC = ((EXT_MIN_NS + EXT_MAX_NS) / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HOST_DIS_CYC = (DIS_NS + CLK_NS - 1) / CLK_NS + SYNC_SLACK_CYC;
  localparam int LINK_HALF_CYC = 4;

  typedef enum logic [1:0] {
    RG_FLASH = 2'b00,
    RG_ID = 2'b01,
    RG_CFG = 2'b10,
    RG_EE = 2'b11
  } nps_region_e;

  function automatic logic has_payload(input logic [7:0] op);
    return op == OP_LOAD || op == OP_LOAD_INC || op == OP_LOAD_PC ||
           op == OP_READ || op == OP_READ_INC;
  endfunction

  function automatic nps_region_e region_of(input logic [ADDR_W-1:0] a);
    if (a[21:16] == SEL_ID) return RG_ID;
    if (a[21:16] == SEL_CFG) return RG_CFG;
    if (a[21:16] > SEL_CFG) return RG_EE;
    return RG_FLASH;
  endfunction
endpackage

// ### nps_link_if.sv
// Serial programming link between the host programmer and the device.
interface nps_link_if;
  logic prog_serial_clock;
  logic dat_host;
  logic dat_host_oe;
  logic dat_dev;
  logic dat_dev_oe;
  logic prog_serial_data;

  // The line idles high through a pull-up when nobody drives it.
  assign prog_serial_data = dat_host_oe ? dat_host : (dat_dev_oe ? dat_dev : 1'b1);

  modport dev (input prog_serial_clock, input prog_serial_data,
               output dat_dev, output dat_dev_oe);
  modport host (output prog_serial_clock, output dat_host, output dat_host_oe,
                input prog_serial_data);
endinterface

// ### nps_device.sv
// Device end: serial command receiver, data latches and memory sequencer.
// Notes on behaviour
// - Each load fills one 16-bit latch.
// - Address low bits pick latch; pointer picks target.
// - Writes stay inside the addressed row.
// - Excess loads wrap and overwrite latches.
// - Flash by row, ID/config by word, EEPROM by byte.
// - Protected flash reads over the link return zero.
// - Protected flash refuses programming; application bypasses.
// - ID always programmable, config only when unprotected; both always readable.
// - Program protect cleared only by full bulk erase.
// - EEPROM protect cleared only by bulk erase.
// - Unprotected checksum sums flash plus masked config.
// - Protected checksum sums IDs plus masked config.
// - Host waits one microsecond between commands, undriven.
// - Bulk erase ends within 25.2 ms.
// - Row erase ends within 2.8 ms.
// - Self-timed write ends within 2.8 or 5.6 ms.
// - Host ends timed write between 1.0-2.1 ms.
// - Host waits 300 us after end command.
// - Host-timed config writes have no effect.
// - Host waits one microsecond after leaving mode; the host end has no exit step and never uses HOST_EXIT_CYC.
// - Commands E0, C0 and 82 decoded.
// - Self-timed resets latches; refused under any protection.
// - Stray end command is a no-operation.
module nps_device #(
  parameter int ROW_WORDS = 32,
  parameter int FLASH_ROWS = 4,
  parameter int EE_BYTES = 16,
  parameter int ID_WORDS = 8,
  parameter int CFG_WORDS = 6,
  parameter int BULK_CYC = nps_pkg::DEV_BULK_CYC,
  parameter int ROW_CYC = nps_pkg::DEV_ROW_CYC,
  parameter int WR_FAST_CYC = nps_pkg::DEV_WR_FAST_CYC,
  parameter int WR_SLOW_CYC = nps_pkg::DEV_WR_SLOW_CYC
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Programming link.
  nps_link_if.dev link,
  // Running application access to flash.
  input wire logic app_we_i,
  input wire logic [$clog2(ROW_WORDS*FLASH_ROWS)-1:0] app_addr_i,
  input wire logic [nps_pkg::DATA_W-1:0] app_wdata_i,
  output logic [nps_pkg::DATA_W-1:0] app_rdata_o,
  // Status.
  output logic program_protect_n_o,
  output logic eeprom_protect_n_o,
  output logic busy_o
);
  import nps_pkg::*;

  localparam int FW = ROW_WORDS * FLASH_ROWS;
  localparam int LAW = $clog2(ROW_WORDS);
  localparam int FAW = $clog2(FW);
  localparam int EAW = $clog2(EE_BYTES);
  localparam int IAW = $clog2(ID_WORDS);
  localparam int CAW = $clog2(CFG_WORDS);

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_PAY = 2'b01,
    ST_BUSY = 2'b10
  } nps_state_e;

  nps_state_e st;
  logic [2:0] clk_sync;
  logic [2:0] dat_sync;
  logic clk_lvl;
  logic dat_lvl;
  logic fall;
  logic [4:0] cnt;
  logic [PAY_BITS-1:0] shreg;
  logic [PAY_BITS-1:0] out_sh;
  logic [7:0] op;
  logic [ADDR_W-1:0] address_pointer;
  logic ext_on;
  logic clr_lat;
  logic [31:0] busy_cnt;
  logic [DATA_W-1:0] latch [ROW_WORDS];
  logic [DATA_W-1:0] program_flash_array [FW];
  logic [7:0] ee [EE_BYTES];
  logic [DATA_W-1:0] id [ID_WORDS];
  logic [DATA_W-1:0] cfg [CFG_WORDS];
  logic program_protect_n;
  logic eeprom_protect_n;
  logic cmd_done;
  logic pay_done;
  logic [7:0] cmd_byte;
  logic [PAY_BITS-1:0] pay;
  nps_region_e rgn;
  logic [FAW-1:0] fidx;
  logic [LAW-1:0] lidx;
  logic [CAW-1:0] cidx;
  logic self_go;
  logic ext_go;
  logic ext_end;
  logic commit;
  logic row_go;
  logic bulk_go;
  logic bulk_fl;
  logic bulk_ee;
  logic lat_reset;
  logic [DATA_W-1:0] rd_val;
  logic [31:0] next_busy;

  // The pin levels count only once the second and third stages agree.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sync <= 3'h0;
      dat_sync <= 3'h7;
      clk_lvl <= 1'b0;
      dat_lvl <= 1'b1;
    end else begin
      clk_sync <= {clk_sync[1:0], link.prog_serial_clock};
      dat_sync <= {dat_sync[1:0], link.prog_serial_data};
      if (clk_sync[1] == clk_sync[2]) clk_lvl <= clk_sync[2];
      if (dat_sync[1] == dat_sync[2]) dat_lvl <= dat_sync[2];
    end
  end

  assign fall = clk_lvl && clk_sync[1] == clk_sync[2] && !clk_sync[2];
  assign program_protect_n = cfg[PROT_WORD][PROT_CP_BIT];
  assign eeprom_protect_n = cfg[PROT_WORD][PROT_CPD_BIT];
  assign cmd_byte = {shreg[6:0], dat_lvl};
  assign pay = {shreg[PAY_BITS-2:0], dat_lvl};
  assign cmd_done = st == ST_CMD && fall && cnt == 5'(CMD_BITS - 1);
  assign pay_done = st == ST_PAY && fall && cnt == 5'(PAY_BITS - 1);
  assign rgn = region_of(address_pointer);
  assign fidx = address_pointer[FAW:1];
  assign cidx = address_pointer[CAW:1];
  assign lidx = (rgn == RG_EE) ? address_pointer[LAW-1:0] : address_pointer[LAW:1];

  assign self_go = cmd_done && cmd_byte == OP_SELF && !ext_on &&
                   program_protect_n && eeprom_protect_n;
  assign ext_go = cmd_done && cmd_byte == OP_EXT_BEGIN && !ext_on &&
                  !(rgn == RG_FLASH && !program_protect_n) &&
                  !(rgn == RG_EE && !eeprom_protect_n);
  assign ext_end = cmd_done && cmd_byte == OP_EXT_END && ext_on;
  assign commit = self_go || ext_end;
  assign row_go = cmd_done && cmd_byte == OP_ROW && rgn == RG_FLASH && program_protect_n;
  assign bulk_go = cmd_done && cmd_byte == OP_BULK;
  assign bulk_fl = rgn == RG_FLASH || rgn == RG_CFG;
  assign bulk_ee = rgn == RG_EE || (bulk_fl && !(program_protect_n && eeprom_protect_n));
  assign lat_reset = st == ST_BUSY && busy_cnt == 32'h1 && clr_lat;

  always_comb begin
    next_busy = 32'(BULK_CYC);
    if (row_go) next_busy = 32'(ROW_CYC);
    else if (self_go && rgn == RG_FLASH) next_busy = 32'(WR_FAST_CYC);
    else if (self_go && rgn == RG_ID) next_busy = 32'(WR_FAST_CYC);
    else if (self_go) next_busy = 32'(WR_SLOW_CYC);
  end

  always_comb begin
    case (rgn)
      RG_FLASH: rd_val = program_protect_n ? program_flash_array[fidx] : 16'h0000;
      RG_ID: rd_val = id[address_pointer[IAW:1]];
      RG_CFG: rd_val = (32'(cidx) < CFG_WORDS) ? cfg[cidx] : 16'h0000;
      default: rd_val = {8'h00, ee[address_pointer[EAW-1:0]]};
    endcase
  end

  // Sequencer: edges are not even counted while a timed cycle runs.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_CMD;
      cnt <= 5'h00;
      op <= 8'h00;
      busy_cnt <= 32'h0;
    end else begin
      case (st)
        ST_CMD: begin
          if (cmd_done) begin
            cnt <= 5'h00;
            op <= cmd_byte;
            if (has_payload(cmd_byte)) begin
              st <= ST_PAY;
            end else if (self_go || row_go || bulk_go) begin
              st <= ST_BUSY;
              busy_cnt <= next_busy;
            end
          end else if (fall) begin
            cnt <= cnt + 5'h01;
          end
        end
        ST_PAY: begin
          if (pay_done) begin
            cnt <= 5'h00;
            st <= ST_CMD;
          end else if (fall) begin
            cnt <= cnt + 5'h01;
          end
        end
        ST_BUSY: begin
          busy_cnt <= busy_cnt - 32'h1;
          if (busy_cnt <= 32'h1) st <= ST_CMD;
        end
        default: st <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) shreg <= '0;
    else if (fall && st != ST_BUSY) shreg <= pay;
  end

  // A stray end command leaves everything as it was.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) ext_on <= 1'b0;
    else if (ext_go) ext_on <= 1'b1;
    else if (ext_end) ext_on <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) clr_lat <= 1'b0;
    else if (self_go) clr_lat <= 1'b1;
    else if (st != ST_BUSY) clr_lat <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      address_pointer <= '0;
    end else if (pay_done && op == OP_LOAD_PC) begin
      address_pointer <= pay[ADDR_W:1];
    end else if ((cmd_done && cmd_byte == OP_INC) ||
                 (pay_done && (op == OP_LOAD_INC || op == OP_READ_INC))) begin
      address_pointer <= address_pointer + ((rgn == RG_EE) ? 22'h000001 : 22'h000002);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ROW_WORDS; i++) latch[i] <= LATCH_RESET;
    end else if (lat_reset) begin
      for (int i = 0; i < ROW_WORDS; i++) latch[i] <= LATCH_RESET;
    end else if (pay_done && (op == OP_LOAD || op == OP_LOAD_INC)) begin
      latch[lidx] <= pay[DATA_W:1];
    end
  end

  // Link writes only clear bits, so a commit ANDs the latch into the cell; application writes replace it.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < FW; i++) program_flash_array[i] <= 16'hFFFF;
    end else begin
      for (int i = 0; i < FW; i++) begin
        if (bulk_go && bulk_fl) begin
          program_flash_array[i] <= 16'hFFFF;
        end else if ((FAW'(i) >> LAW) == (fidx >> LAW)) begin
          if (row_go) begin
            program_flash_array[i] <= 16'hFFFF;
          end else if (commit && rgn == RG_FLASH && program_protect_n) begin
            program_flash_array[i] <= program_flash_array[i] & latch[LAW'(i)];
          end
        end
      end
      if (app_we_i) program_flash_array[app_addr_i] <= app_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < EE_BYTES; i++) ee[i] <= 8'hFF;
    end else if (bulk_go && bulk_ee) begin
      for (int i = 0; i < EE_BYTES; i++) ee[i] <= 8'hFF;
    end else if (commit && rgn == RG_EE && eeprom_protect_n) begin
      ee[address_pointer[EAW-1:0]] <= ee[address_pointer[EAW-1:0]] & latch[lidx][7:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ID_WORDS; i++) id[i] <= 16'hFFFF;
    end else if (bulk_go && rgn == RG_CFG) begin
      for (int i = 0; i < ID_WORDS; i++) id[i] <= 16'hFFFF;
    end else if (commit && rgn == RG_ID) begin
      id[address_pointer[IAW:1]] <= id[address_pointer[IAW:1]] & latch[lidx];
    end
  end

  // Protection bits live in a config word, so only a bulk erase sets them.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < CFG_WORDS; i++) cfg[i] <= CFG_RESET;
    end else if (bulk_go && bulk_fl) begin
      for (int i = 0; i < CFG_WORDS; i++) cfg[i] <= CFG_RESET;
    end else if (self_go && rgn == RG_CFG && 32'(cidx) < CFG_WORDS) begin
      cfg[cidx] <= cfg[cidx] & latch[lidx];
    end
  end

  // Read data leaves on falling edges while the device owns the line.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      out_sh <= '0;
      link.dat_dev_oe <= 1'b0;
    end else if (cmd_done && (cmd_byte == OP_READ || cmd_byte == OP_READ_INC)) begin
      out_sh <= {7'h00, rd_val, 1'b0};
      link.dat_dev_oe <= 1'b1;
    end else if (pay_done) begin
      link.dat_dev_oe <= 1'b0;
    end else if (st == ST_PAY && fall) begin
      out_sh <= {out_sh[PAY_BITS-2:0], 1'b0};
    end
  end

  assign link.dat_dev = out_sh[PAY_BITS-1];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      app_rdata_o <= 16'h0000;
      program_protect_n_o <= 1'b1;
      eeprom_protect_n_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      app_rdata_o <= program_flash_array[app_addr_i];
      program_protect_n_o <= program_protect_n;
      eeprom_protect_n_o <= eeprom_protect_n;
      busy_o <= st == ST_BUSY || ext_on;
    end
  end
endmodule

// ### nps_host.sv
// Host end: drives the serial clock, frames commands and keeps the delays.
module nps_host #(
  parameter int HALF_CYC = nps_pkg::LINK_HALF_CYC,
  parameter int GAP_CYC = nps_pkg::HOST_GAP_CYC,
  parameter int BULK_CYC = nps_pkg::HOST_BULK_CYC,
  parameter int ROW_CYC = nps_pkg::HOST_ROW_CYC,
  parameter int WR_CYC = nps_pkg::HOST_WR_CYC,
  parameter int EXT_CYC = nps_pkg::HOST_EXT_CYC,
  parameter int DIS_CYC = nps_pkg::HOST_DIS_CYC
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Programming link.
  nps_link_if.host link,
  // Command request.
  input wire logic req_valid_i,
  input wire logic [7:0] req_op_i,
  input wire logic [nps_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [nps_pkg::DATA_W-1:0] req_data_i,
  output logic req_ready_o,
  // Read answer and checksum.
  output logic rd_valid_o,
  output logic [nps_pkg::DATA_W-1:0] rd_data_o,
  input wire logic [nps_pkg::DATA_W-1:0] sum_mask_i,
  input wire logic sum_clear_i,
  output logic [nps_pkg::DATA_W-1:0] checksum_o
);
  import nps_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CMD = 3'b001,
    H_GAP = 3'b010,
    H_PAY = 3'b011,
    H_WAIT = 3'b100
  } nps_hstate_e;

  nps_hstate_e hs;
  logic [7:0] op;
  logic [PAY_BITS-1:0] sh;
  logic [PAY_BITS-1:0] pay;
  logic [PAY_BITS-1:0] rsh;
  logic [4:0] nbit;
  logic [7:0] ph;
  logic [31:0] wait_cnt;
  logic [2:0] dat_sync;
  logic dat_lvl;
  logic reading;
  logic bit_end;
  logic last_bit;

  function automatic logic [31:0] wait_for(input logic [7:0] o);
    case (o)
      OP_BULK: return 32'(BULK_CYC);
      OP_ROW: return 32'(ROW_CYC);
      OP_SELF: return 32'(WR_CYC);
      OP_EXT_BEGIN: return 32'(EXT_CYC);
      OP_EXT_END: return 32'(DIS_CYC);
      default: return 32'(GAP_CYC);
    endcase
  endfunction

  assign reading = hs == H_PAY && (op == OP_READ || op == OP_READ_INC);
  assign bit_end = (hs == H_CMD || hs == H_PAY) && ph == 8'(2 * HALF_CYC - 1);
  assign last_bit = nbit == ((hs == H_CMD) ? 5'(CMD_BITS - 1) : 5'(PAY_BITS - 1));
  assign req_ready_o = hs == H_IDLE;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dat_sync <= 3'h7;
      dat_lvl <= 1'b1;
    end else begin
      dat_sync <= {dat_sync[1:0], link.prog_serial_data};
      if (dat_sync[1] == dat_sync[2]) dat_lvl <= dat_sync[2];
    end
  end

  // The clock idles low; data changes on the rising edge and the device
  // takes it on the falling edge, half a period later.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hs <= H_IDLE;
      op <= 8'h00;
      sh <= '0;
      pay <= '0;
      nbit <= 5'h00;
      ph <= 8'h00;
      wait_cnt <= 32'h0;
      link.prog_serial_clock <= 1'b0;
      link.dat_host <= 1'b0;
      link.dat_host_oe <= 1'b0;
    end else begin
      case (hs)
        H_IDLE: begin
          if (req_valid_i) begin
            op <= req_op_i;
            sh <= {req_op_i, 16'h0000};
            pay <= (req_op_i == OP_LOAD_PC) ? {1'b0, req_addr_i, 1'b0} :
                   {7'h00, req_data_i, 1'b0};
            nbit <= 5'h00;
            ph <= 8'h00;
            hs <= H_CMD;
          end
        end
        H_CMD, H_PAY: begin
          ph <= bit_end ? 8'h00 : ph + 8'h01;
          if (ph == 8'h00) begin
            link.prog_serial_clock <= 1'b1;
            link.dat_host <= sh[PAY_BITS-1];
            link.dat_host_oe <= !reading;
          end else if (ph == 8'(HALF_CYC)) begin
            link.prog_serial_clock <= 1'b0;
          end
          if (bit_end) begin
            sh <= {sh[PAY_BITS-2:0], 1'b0};
            nbit <= nbit + 5'h01;
            if (last_bit) begin
              link.dat_host_oe <= 1'b0;
              nbit <= 5'h00;
              if (hs == H_CMD && has_payload(op)) begin
                hs <= H_GAP;
                wait_cnt <= 32'(GAP_CYC);
              end else begin
                hs <= H_WAIT;
                wait_cnt <= (hs == H_PAY) ? 32'(GAP_CYC) : wait_for(op);
              end
            end
          end
        end
        H_GAP: begin
          wait_cnt <= wait_cnt - 32'h1;
          if (wait_cnt <= 32'h1) begin
            sh <= pay;
            ph <= 8'h00;
            hs <= H_PAY;
          end
        end
        H_WAIT: begin
          wait_cnt <= wait_cnt - 32'h1;
          if (wait_cnt <= 32'h1) begin
            // A host-timed write is always closed inside its window.
            if (op == OP_EXT_BEGIN) begin
              op <= OP_EXT_END;
              sh <= {OP_EXT_END, 16'h0000};
              ph <= 8'h00;
              hs <= H_CMD;
            end else begin
              hs <= H_IDLE;
            end
          end
        end
        default: hs <= H_IDLE;
      endcase
    end
  end

  // Read bits are taken late in the high phase to cover both synchronisers.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsh <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
      checksum_o <= 16'h0000;
    end else begin
      rd_valid_o <= 1'b0;
      if (reading && ph == 8'(HALF_CYC - 1)) rsh <= {rsh[PAY_BITS-2:0], dat_lvl};
      if (reading && bit_end && last_bit) begin
        rd_valid_o <= 1'b1;
        rd_data_o <= rsh[DATA_W-1:0];
      end
      if (sum_clear_i) checksum_o <= 16'h0000;
      else if (rd_valid_o) checksum_o <= checksum_o + (rd_data_o & sum_mask_i);
    end
  end
endmodule

// ### nps_link_sva.sv
// Checker for the serial programming link between the host and device ends.
module nps_link_sva (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Link signals.
  input wire logic prog_serial_clock,
  input wire logic dat_host,
  input wire logic dat_host_oe,
  input wire logic dat_dev,
  input wire logic dat_dev_oe,
  input wire logic prog_serial_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_fall;
    $fell(prog_serial_clock);
  endsequence
  sequence s_quiet;
    (!dat_host_oe && !prog_serial_clock) [*8];
  endsequence
  a_no_contention: assert property (!(dat_host_oe && dat_dev_oe))
    else $error("Both ends drive the data line.");
  a_line_pullup: assert property (!dat_host_oe && !dat_dev_oe |-> prog_serial_data)
    else $error("Released data line is not high.");
  a_host_level: assert property (dat_host_oe |-> prog_serial_data == dat_host)
    else $error("Line does not follow host data.");
  a_dev_level: assert property (dat_dev_oe |-> prog_serial_data == dat_dev)
    else $error("Line does not follow device data.");
  a_clk_high: assert property ($rose(prog_serial_clock) |-> prog_serial_clock [*4])
    else $error("Serial clock high phase too short.");
  a_clk_low: assert property (s_fall |-> !prog_serial_clock [*4])
    else $error("Serial clock low phase too short.");
  a_data_hold: assert property (s_fall ##0 dat_host_oe |-> $stable(dat_host))
    else $error("Host data moved at the sampling edge.");
  a_gap_quiet: assert property ($fell(dat_host_oe) |=> s_quiet)
    else $error("Link not quiet after a host field.");
  a_dev_release: assert property ($fell(dat_dev_oe) |-> !prog_serial_clock)
    else $error("Device released the line inside a bit.");
endmodule

// ### testbench.sv
// Self-checking bench joining the host and device ends over the link.
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nps_pkg::*;
  localparam int D_BULK = 50, D_ROW = 20, D_FAST = 20, D_SLOW = 40, H_EXT = 30, N_ROW = 4;
  logic clock_i = 0, rst_i = 1, req_valid = 0, sum_clear = 0, app_we = 0;
  logic [7:0] req_op = 8'h00;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_data = 16'h0000, app_wdata = 16'h0000, sum_mask = 16'hFFFF;
  logic [3:0] app_addr = 4'h0;
  logic req_ready_o, rd_valid_o, pp_n, ep_n, busy_o;
  logic [15:0] rd_data_o, checksum_o, app_rdata_o;
  int n_mismatch = 0, samples_checked = 0, n_rd = 0;
  nps_link_if link ();
  nps_host #(.BULK_CYC(D_BULK + SYNC_SLACK_CYC), .ROW_CYC(D_ROW + SYNC_SLACK_CYC),
    .WR_CYC(D_SLOW + SYNC_SLACK_CYC), .EXT_CYC(H_EXT), .DIS_CYC(H_EXT)) u_nps_host (
    .clock_i(clock_i), .rst_i(rst_i), .link(link), .req_valid_i(req_valid),
    .req_op_i(req_op), .req_addr_i(req_addr), .req_data_i(req_data),
    .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .sum_mask_i(sum_mask), .sum_clear_i(sum_clear), .checksum_o(checksum_o));
  nps_device #(.ROW_WORDS(N_ROW), .BULK_CYC(D_BULK), .ROW_CYC(D_ROW), .WR_FAST_CYC(D_FAST),
    .WR_SLOW_CYC(D_SLOW)) u_nps_device (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .app_we_i(app_we), .app_addr_i(app_addr), .app_wdata_i(app_wdata),
    .app_rdata_o(app_rdata_o), .program_protect_n_o(pp_n), .eeprom_protect_n_o(ep_n),
    .busy_o(busy_o));
  nps_link_sva u_nps_link_sva (.clock_i(clock_i), .rst_i(rst_i),
    .prog_serial_clock(link.prog_serial_clock), .dat_host(link.dat_host),
    .dat_host_oe(link.dat_host_oe), .dat_dev(link.dat_dev), .dat_dev_oe(link.dat_dev_oe),
    .prog_serial_data(link.prog_serial_data));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (rd_valid_o === 1'b1) n_rd++;
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 5000);
    if (req_ready_o !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t: host never ready", $time);
    end
  endtask
  // Host waits are built into the host end, so a request only needs the idle handshake.
  task automatic cmd(input logic [7:0] op, input logic [21:0] a, input logic [15:0] d);
    idle();
    @(posedge clock_i);
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge clock_i);
    req_valid <= 1'b0;
    idle();
  endtask
  task automatic rd(input logic [21:0] a);
    int k;
    k = n_rd;
    cmd(OP_LOAD_PC, a, 16'h0000);
    cmd(OP_READ, 22'h000000, 16'h0000);
    `CHK(n_rd, k + 1)
  endtask
  task automatic peek(input logic [3:0] a);
    @(posedge clock_i);
    app_addr <= a;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic clr_sum();
    @(posedge clock_i) sum_clear <= 1'b1;
    @(posedge clock_i) sum_clear <= 1'b0;
  endtask
  // Five loads into a four-latch row wrap round; the commit pointer sits on the row's last word.
  task automatic t_rows();
    for (int i = 0; i < 5; i++) cmd(OP_LOAD_INC, 22'h000000, 16'h0A00 + 16'(i));
    cmd(OP_LOAD_PC, 22'h000006, 16'h0000);
    cmd(OP_SELF, 22'h000000, 16'h0000);
    peek(4'h0);
    `CHK(app_rdata_o, 16'h0A04)
    peek(4'h3);
    `CHK(app_rdata_o, 16'h0A03)
    peek(4'h4);
    `CHK(app_rdata_o, 16'hFFFF)
    cmd(OP_LOAD_PC, 22'h000008, 16'h0000);
    cmd(OP_SELF, 22'h000000, 16'h0000);
    rd(22'h000008);
    `CHK(rd_data_o, 16'hFFFF)
    clr_sum();
    rd(22'h000002);
    `CHK(rd_data_o, 16'h0A01)
    rd(22'h000004);
    `CHK(checksum_o, 16'h1403)
    @(posedge clock_i) sum_mask <= 16'h00FF;
    rd(22'h000006);
    `CHK(checksum_o, 16'h1406)
  endtask
  // Setting both protect bits locks the flash until a full bulk erase.
  task automatic t_prot();
    cmd(OP_LOAD_PC, 22'h300008, 16'h0000);
    cmd(OP_LOAD, 22'h000000, 16'hFFFC);
    cmd(OP_SELF, 22'h000000, 16'h0000);
    `CHK({pp_n, ep_n}, 2'b00)
    rd(22'h000000);
    `CHK(rd_data_o, 16'h0000)
    clr_sum();
    rd(22'h200000);
    rd(22'h300008);
    `CHK(rd_data_o, 16'hFFFC)
    `CHK(checksum_o, 16'h01FB)
    cmd(OP_LOAD_PC, 22'h000000, 16'h0000);
    cmd(OP_LOAD, 22'h000000, 16'h0000);
    cmd(OP_SELF, 22'h000000, 16'h0000);
    cmd(OP_ROW, 22'h000000, 16'h0000);
    peek(4'h0);
    `CHK(app_rdata_o, 16'h0A04)
    @(posedge clock_i) {app_we, app_addr, app_wdata} <= {1'b1, 4'h5, 16'h1234};
    @(posedge clock_i) app_we <= 1'b0;
    peek(4'h5);
    `CHK(app_rdata_o, 16'h1234)
    cmd(OP_BULK, 22'h000000, 16'h0000);
    `CHK({pp_n, ep_n, busy_o}, 3'b110)
    peek(4'h0);
    `CHK(app_rdata_o, 16'hFFFF)
  endtask
  // Host-timed writes reach flash but never a configuration word.
  task automatic t_ext();
    cmd(OP_LOAD_PC, 22'h000000, 16'h0000);
    cmd(OP_LOAD, 22'h000000, 16'h5555);
    cmd(OP_EXT_BEGIN, 22'h000000, 16'h0000);
    cmd(OP_LOAD, 22'h000000, 16'h0000);
    cmd(OP_EXT_END, 22'h000000, 16'h0000);
    peek(4'h0);
    `CHK(app_rdata_o, 16'h5555)
    cmd(OP_LOAD_PC, 22'h300000, 16'h0000);
    cmd(OP_LOAD, 22'h000000, 16'h0000);
    cmd(OP_EXT_BEGIN, 22'h000000, 16'h0000);
    rd(22'h300000);
    `CHK(rd_data_o, 16'hFFFF)
    cmd(OP_LOAD_PC, 22'h000000, 16'h0000);
    cmd(OP_ROW, 22'h000000, 16'h0000);
    peek(4'h0);
    `CHK(app_rdata_o, 16'hFFFF)
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    t_rows();
    t_prot();
    t_ext();
    print_verdict();
  end
  // The whole sequence needs about 16500 cycles; about five times that means a hang.
  initial begin
    #800us;
    n_mismatch++;
    print_verdict();
  end
endmodule
